/* rtl/uasp_defs.svh */
`ifndef UASP_DEFS_SVH
`define UASP_DEFS_SVH
// Contract
// - Mode bit 0 selects 8-bit framing, 1 selects 9-bit framing.
// - 8-bit frame: start, eight data bits, stop; ten bit times.
// - Data bits go out and come in least significant bit first.
// - 8-bit mode: accepted byte to receive buffer, stop bit to ninth receive bit.
// - Writing the data buffer starts a transmit frame; the code queues writes four deep and drops a write while the queue is full.
// - Transmit-done flag sets as the stop bit time begins.
// - Reception starts only while the receive enable bit is 1.
// - 8-bit accept needs receive flag 0, and stop 1 when checking enabled.
// - Rejected frame leaves buffer, ninth bit and receive flag untouched.
// - On overrun the first byte stays latched; later bytes are lost.
// - 9-bit frame: start, eight data, ninth bit, stop; eleven bit times.
// - 9-bit mode sends the ninth transmit bit; unused in 8-bit mode.
// - 9-bit mode stores the ninth data bit, ignores the stop bit level.
// - 9-bit accept needs receive flag 0, and ninth 1 when check enabled.
// - Interrupt requested when either flag is set and interrupts enabled.
// - Flags are cleared only by software writes, never by hardware.
// - Receive flag sets when the stop bit is sampled.
// - Control bit 6 reads as 1; writes to it are ignored.
// - Baud timer may tick from another source than the system clock.
// - Bit rate is half the 8-bit auto-reload timer overflow rate.
// - Start detection forces a receive timer reload.
// - Data writes go to transmit side; reads return the receive buffer.
`define UASP_CTRL_ADDR 8'h98
`define UASP_DATA_ADDR 8'h99
`define UASP_CTRL_RESET 8'h40
`define UASP_B_MODE 7
`define UASP_B_MCE 5
`define UASP_B_REN 4
`define UASP_B_TB8 3
`define UASP_B_RB8 2
`define UASP_B_TI 1
`define UASP_B_RI 0
`define UASP_TMR_TOP 8'hff
`define UASP_BITS_8 4'ha
`define UASP_BITS_9 4'hb
`define UASP_RX_LAST_8 4'h8
`define UASP_RX_LAST_9 4'h9
`define UASP_FIFO_DEPTH 4
`endif

/* rtl/uasp_pkg.sv */
package uasp_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uasp_sfr_req_t;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } uasp_txw_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uasp_rx_st_t;
endpackage : uasp_pkg

/* rtl/uasp_top.sv */
`timescale 1ns/10ps
`include "uasp_defs.svh"

module uasp_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Count is one bit wider than the pointers so a full buffer differs from an empty one
    assign in_ready = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : uasp_fifo

module uasp_top
    import uasp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Special-function register port
    input wire uasp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Baud timer
    input wire logic timer_tick,
    input wire logic [7:0] baud_timer_reload,
    // Interrupt
    input wire logic irq_enable,
    output logic uart_irq,
    // Serial lines
    input wire logic serial_in_line,
    output logic serial_out_line,
    // Transmit buffer status
    output logic tx_space
);
    function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction : sfr_hit

    // One wrap decode serves both bit timers
    function automatic logic tmr_wrap(input logic [7:0] t);
        return t == `UASP_TMR_TOP;
    endfunction : tmr_wrap

    logic frame_mode_select_q;
    logic multiprocessor_check_enable_q;
    logic receive_enable_bit_q;
    logic ninth_transmit_bit_q;
    logic ninth_receive_bit_q;
    logic transmit_done_flag_q;
    logic receive_done_flag_q;
    logic [7:0] rx_buf_q;
    logic ctrl_wr;
    logic data_wr;
    logic ti_set;
    logic ri_set;
    logic rx_done;
    logic rx_nine;
    logic [7:0] rx_byte;
    logic rx_accept;
    logic fifo_in_ready;

    assign ctrl_wr = sfr_req.wr && sfr_hit(sfr_req.addr, `UASP_CTRL_ADDR);
    assign data_wr = sfr_req.wr && sfr_hit(sfr_req.addr, `UASP_DATA_ADDR);

    // Control register; bit 6 has no storage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_mode_select_q <= 1'b0;
            multiprocessor_check_enable_q <= 1'b0;
            receive_enable_bit_q <= 1'b0;
            ninth_transmit_bit_q <= 1'b0;
        end else if (ctrl_wr) begin
            frame_mode_select_q <= sfr_req.wdata[`UASP_B_MODE];
            multiprocessor_check_enable_q <= sfr_req.wdata[`UASP_B_MCE];
            receive_enable_bit_q <= sfr_req.wdata[`UASP_B_REN];
            ninth_transmit_bit_q <= sfr_req.wdata[`UASP_B_TB8];
        end
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            transmit_done_flag_q <= 1'b0;
            receive_done_flag_q <= 1'b0;
            ninth_receive_bit_q <= 1'b0;
        end else begin
            if (ti_set) begin
                transmit_done_flag_q <= 1'b1;
            end else if (ctrl_wr) begin
                transmit_done_flag_q <= sfr_req.wdata[`UASP_B_TI];
            end
            if (ri_set) begin
                receive_done_flag_q <= 1'b1;
            end else if (ctrl_wr) begin
                receive_done_flag_q <= sfr_req.wdata[`UASP_B_RI];
            end
            if (ri_set) begin
                ninth_receive_bit_q <= rx_nine;
            end else if (ctrl_wr) begin
                ninth_receive_bit_q <= sfr_req.wdata[`UASP_B_RB8];
            end
        end
    end

    // Read port
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            if (sfr_hit(sfr_req.addr, `UASP_CTRL_ADDR)) begin
                sfr_rdata <= {frame_mode_select_q, 1'b1, multiprocessor_check_enable_q,
                    receive_enable_bit_q, ninth_transmit_bit_q, ninth_receive_bit_q,
                    transmit_done_flag_q, receive_done_flag_q};
            end else if (sfr_hit(sfr_req.addr, `UASP_DATA_ADDR)) begin
                sfr_rdata <= rx_buf_q;
            end else begin
                // Unmapped addresses read as zero
                sfr_rdata <= 8'h00;
            end
        end
    end

    // Level request: it drops once software has cleared both flags or irq_enable goes low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            uart_irq <= 1'b0;
            tx_space <= 1'b1;
        end else begin
            uart_irq <= irq_enable && (transmit_done_flag_q || receive_done_flag_q);
            tx_space <= fifo_in_ready;
        end
    end

    // Transmit side
    logic fifo_out_valid;
    logic fifo_out_ready;
    uasp_txw_t fifo_in;
    uasp_txw_t fifo_out;
    logic [7:0] tx_tmr_q;
    logic tx_half_q;
    logic tx_bit_tick;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic tx_start;

    // Ninth bit is captured with the byte so a later control write cannot alter it; the mode bit is read when the frame starts
    assign fifo_in.ninth = ninth_transmit_bit_q;
    assign fifo_in.data = sfr_req.wdata;

    uasp_fifo #(.W($bits(uasp_txw_t)), .D(`UASP_FIFO_DEPTH)) u_tx_fifo (
        .clk(ref_clk),
        .rst_n(reset_n),
        .in_valid(data_wr),
        .in_data(fifo_in),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out),
        .out_ready(fifo_out_ready)
    );

    // Timer ticks come as an enable, so the tick source need not be the system clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_tmr_q <= 8'h00;
            tx_half_q <= 1'b0;
        end else if (timer_tick) begin
            if (tmr_wrap(tx_tmr_q)) begin
                tx_tmr_q <= baud_timer_reload;
                tx_half_q <= ~tx_half_q;
            end else begin
                tx_tmr_q <= tx_tmr_q + 8'h01;
            end
        end
    end

    assign tx_bit_tick = timer_tick && tmr_wrap(tx_tmr_q) && tx_half_q;
    assign fifo_out_ready = tx_bit_tick && tx_left_q <= 4'h1;
    assign tx_start = fifo_out_ready && fifo_out_valid;
    assign ti_set = tx_bit_tick && tx_left_q == 4'h2;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_sh_q <= 11'h7ff;
            tx_left_q <= 4'h0;
            serial_out_line <= 1'b1;
        end else if (tx_start) begin
            if (frame_mode_select_q) begin
                tx_sh_q <= {1'b1, fifo_out.ninth, fifo_out.data, 1'b0};
                tx_left_q <= `UASP_BITS_9;
            end else begin
                tx_sh_q <= {2'b11, fifo_out.data, 1'b0};
                tx_left_q <= `UASP_BITS_8;
            end
            serial_out_line <= 1'b0;
        // Ones fill from the top, so the line rests high after the stop bit
        end else if (tx_bit_tick && tx_left_q != 4'h0) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_left_q <= tx_left_q - 4'h1;
            serial_out_line <= tx_sh_q[1];
        end
    end

    // Receive side
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_s3_q;
    uasp_rx_st_t rx_st_q;
    logic [7:0] rx_tmr_q;
    logic rx_half_q;
    logic rx_sample;
    logic start_det;
    logic rx_mode_q;
    logic [3:0] rx_idx_q;
    logic [9:0] rx_sh_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else begin
            rx_s1_q <= serial_in_line;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    assign start_det = rx_st_q == RX_IDLE && receive_enable_bit_q && rx_s3_q && !rx_s2_q;

    // First overflow after the forced reload lands mid start bit, then every second one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_tmr_q <= 8'h00;
            rx_half_q <= 1'b0;
        end else if (start_det) begin
            rx_tmr_q <= baud_timer_reload;
            rx_half_q <= 1'b0;
        end else if (timer_tick) begin
            if (tmr_wrap(rx_tmr_q)) begin
                rx_tmr_q <= baud_timer_reload;
                rx_half_q <= ~rx_half_q;
            end else begin
                rx_tmr_q <= rx_tmr_q + 8'h01;
            end
        end
    end

    assign rx_sample = timer_tick && tmr_wrap(rx_tmr_q) && !rx_half_q;
    assign rx_done = rx_st_q == RX_BITS && rx_sample
        && rx_idx_q == (rx_mode_q ? `UASP_RX_LAST_9 : `UASP_RX_LAST_8);
    assign rx_byte = rx_mode_q ? rx_sh_q[8:1] : rx_sh_q[9:2];
    assign rx_nine = rx_mode_q ? rx_sh_q[9] : rx_s2_q;
    // Receive flag still set means overrun: the new frame is dropped
    assign rx_accept = !receive_done_flag_q && (!multiprocessor_check_enable_q || rx_nine);
    assign ri_set = rx_done && rx_accept;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_q <= RX_IDLE;
            rx_mode_q <= 1'b0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 10'h000;
        end else begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    if (start_det) begin
                        rx_st_q <= RX_START;
                        // Mode is held per frame so a mid-frame control write cannot split it
                        rx_mode_q <= frame_mode_select_q;
                    end
                end
                RX_START: begin
                    if (rx_sample) begin
                        // A high level mid start bit is a glitch, not a frame
                        rx_st_q <= rx_s2_q ? RX_IDLE : RX_BITS;
                        rx_idx_q <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (rx_done) begin
                        rx_st_q <= RX_IDLE;
                    end else if (rx_sample) begin
                        rx_sh_q <= {rx_s2_q, rx_sh_q[9:1]};
                        rx_idx_q <= rx_idx_q + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf_q <= 8'h00;
        end else if (ri_set) begin
            rx_buf_q <= rx_byte;
        end
    end
endmodule : uasp_top

/* sim/uasp_monitor.sv */
`timescale 1ns/10ps
module uasp_monitor
    import uasp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port
    input wire uasp_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Timer and interrupt
    input wire logic timer_tick,
    input wire logic [7:0] baud_timer_reload,
    input wire logic irq_enable,
    input wire logic uart_irq,
    // Lines and buffer
    input wire logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic tx_space
);
    logic [6:0] idle_q;
    logic data_wr;
    // A long idle run tells a fresh start from a run of one bits
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) idle_q <= 7'h00;
        else if (!serial_out_line) idle_q <= 7'h00;
        else if (idle_q != 7'h7f) idle_q <= idle_q + 7'h01;
    end
    assign data_wr = sfr_req.wr && sfr_req.addr == 8'h99;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_irq_needs_en: assert property (uart_irq |-> $past(irq_enable))
        else $error("interrupt without enable");
    a_irq_sw_clear: assert property ($fell(uart_irq) |-> !$past(irq_enable) || !$past(irq_enable, 2)
        || $past(sfr_req.wr) || $past(sfr_req.wr, 2) || $past(sfr_req.wr, 3)) else $error("interrupt dropped alone");
    a_bad_addr_zero: assert property (sfr_req.rd && sfr_req.addr != 8'h98 && sfr_req.addr != 8'h99
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_ctrl_bit_six: assert property (sfr_req.rd && sfr_req.addr == 8'h98 |=> sfr_rdata[6])
        else $error("control bit 6 not one");
    a_rdata_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("read data moved");
    a_bit_time: assert property ($changed(serial_out_line) && timer_tick && baud_timer_reload == 8'hfc
        |=> $stable(serial_out_line) [*7]) else $error("bit shorter than two overflows");
    a_write_starts: assert property (data_wr && tx_space && idle_q == 7'h7f |-> ##[1:24] !serial_out_line)
        else $error("write did not start frame");
    a_space_fill: assert property ($fell(tx_space) |-> $past(data_wr) || $past(data_wr, 2))
        else $error("buffer filled without write");
    c_ctrl_read: cover property (sfr_req.rd && sfr_req.addr == 8'h98);
    c_tx_start: cover property ($fell(serial_out_line));
    c_irq: cover property ($rose(uart_irq));
    c_rx_start: cover property ($fell(serial_in_line));
endmodule : uasp_monitor
bind uasp_top uasp_monitor u_uasp_monitor (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .timer_tick(timer_tick), .baud_timer_reload(baud_timer_reload),
    .irq_enable(irq_enable), .uart_irq(uart_irq), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line), .tx_space(tx_space));

/* sim/uasp_remote.sv */
`timescale 1ns/10ps
module uasp_remote #(
    parameter int BIT_NS = 320
) (
    // Serial lines
    input wire logic serial_out_line,
    output logic serial_in_line,
    // Eleven-bit frames when high
    input wire logic nine
);
    logic [10:0] got = '0;
    int frames = 0;
    initial serial_in_line = 1'b1;
    // Mid-bit sampling; stops at mid stop bit so a back-to-back start is not missed
    always begin
        @(negedge serial_out_line);
        got = '0;
        #(BIT_NS / 2);
        for (int k = 0; k < (nine ? 11 : 10); k++) begin
            if (k != 0) #(BIT_NS);
            got[k] = serial_out_line;
        end
        frames++;
    end
    // Line rests high after a frame, as a pulled-up idle line would
    task automatic send(input logic [10:0] bits);
        for (int k = 0; k < (nine ? 11 : 10); k++) begin
            serial_in_line = bits[k];
            #(BIT_NS);
        end
        serial_in_line = 1'b1;
    endtask : send
endmodule : uasp_remote

/* sim/uasp_top_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; $display("ERROR %s exp %h got %h", nm, exp, got); end end
module uasp_top_tb
    import uasp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    uasp_sfr_req_t sfr_req = '0;
    logic timer_tick = 1'b1;
    logic [7:0] reload = 8'hfc;
    logic irq_enable = 1'b0;
    logic nine = 1'b0;
    logic [7:0] sfr_rdata;
    logic uart_irq, rx_line, tx_line, tx_space;
    int failures = 0;
    int checks = 0;
    int f0;
    always #20 ref_clk = ~ref_clk;
    uasp_top u_uasp_top (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .timer_tick(timer_tick), .baud_timer_reload(reload), .irq_enable(irq_enable), .uart_irq(uart_irq),
        .serial_in_line(rx_line), .serial_out_line(tx_line), .tx_space(tx_space));
    uasp_remote u_uasp_remote (.serial_out_line(tx_line), .serial_in_line(rx_line), .nine(nine));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk) sfr_req.wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk) sfr_req.rd <= 1'b0;
        #1 `CHK("sfr_rdata", exp, sfr_rdata)
    endtask : rd_chk
    task automatic tx_chk(input logic [10:0] exp);
        int f;
        f = u_uasp_remote.frames;
        // First frame waits for the transmit timer's second wrap after reset
        for (int k = 0; k < 400 && u_uasp_remote.frames == f; k++) @(posedge ref_clk);
        `CHK("frame_seen", 1'b1, u_uasp_remote.frames != f)
        `CHK("frame", exp, u_uasp_remote.got)
    endtask : tx_chk
    // Margin covers the input synchroniser after the stop bit
    task automatic rx(input logic [10:0] bits);
        // Off the clock edge so the pin never races the synchroniser
        #10;
        u_uasp_remote.send(bits);
        repeat (6) @(posedge ref_clk);
    endtask : rx
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd_chk(8'h98, 8'h40);
        @(posedge ref_clk) irq_enable <= 1'b1;
        wr(8'h98, 8'hff);
        rd_chk(8'h98, 8'hff);
        `CHK("uart_irq", 1'b1, uart_irq)
        wr(8'h98, 8'h00);
        rd_chk(8'h98, 8'h40);
        `CHK("uart_irq", 1'b0, uart_irq)
        rd_chk(8'h9a, 8'h00);
        wr(8'h98, 8'h08);
        wr(8'h99, 8'ha5);
        tx_chk({1'b0, 1'b1, 8'ha5, 1'b0});
        rd_chk(8'h98, 8'h4a);
        @(posedge ref_clk) nine <= 1'b1;
        wr(8'h98, 8'h88);
        wr(8'h99, 8'h3c);
        tx_chk({1'b1, 1'b1, 8'h3c, 1'b0});
        rd_chk(8'h98, 8'hca);
        @(posedge ref_clk) nine <= 1'b0;
        wr(8'h98, 8'h10);
        rx({1'b0, 1'b1, 8'h5a, 1'b0});
        rd_chk(8'h99, 8'h5a);
        rd_chk(8'h98, 8'h55);
        rx({1'b0, 1'b1, 8'h33, 1'b0});
        rd_chk(8'h99, 8'h5a);
        rd_chk(8'h98, 8'h55);
        wr(8'h98, 8'h30);
        rx({1'b0, 1'b0, 8'h77, 1'b0});
        rd_chk(8'h99, 8'h5a);
        rd_chk(8'h98, 8'h70);
        wr(8'h98, 8'h00);
        rx({1'b0, 1'b1, 8'h11, 1'b0});
        rd_chk(8'h98, 8'h40);
        @(posedge ref_clk) nine <= 1'b1;
        wr(8'h98, 8'hb0);
        rx({1'b1, 1'b0, 8'h22, 1'b0});
        rd_chk(8'h98, 8'hf0);
        rx({1'b0, 1'b1, 8'h44, 1'b0});
        rd_chk(8'h99, 8'h44);
        rd_chk(8'h98, 8'hf5);
        wr(8'h98, 8'h90);
        rx({1'b1, 1'b0, 8'h66, 1'b0});
        rd_chk(8'h99, 8'h66);
        rd_chk(8'h98, 8'hd1);
        @(posedge ref_clk) nine <= 1'b0;
        wr(8'h98, 8'h00);
        f0 = u_uasp_remote.frames;
        for (int i = 0; i < 6; i++) wr(8'h99, 8'h10 + 8'(i));
        // Two edges let a refused write and the registered flag settle
        repeat (2) @(posedge ref_clk);
        #1 `CHK("tx_space", 1'b0, tx_space)
        repeat (600) @(posedge ref_clk);
        `CHK("tx_space", 1'b1, tx_space)
        // Four queued words plus the one already shifting out
        `CHK("frames", 5, u_uasp_remote.frames - f0)
        wrap_up();
    end
endmodule : uasp_top_tb
